// ==== pkg/spi_datagram_map.svh ====
`ifndef SPI_DATAGRAM_MAP_SVH
`define SPI_DATAGRAM_MAP_SVH
// datagram layout
`define DG_BITS        40
`define DG_WRITE_BIT   39
`define DG_ADDR_HI     38
`define DG_ADDR_LO     32
`define DG_DATA_HI     31
`define DG_STATUS_BITS 8
`define DG_ADDR_BITS   7
`define DG_DATA_BITS   32
// reset values
`define DG_RET_RESET   32'h00000000
// pin reset levels {select, link clock, data in}: select idles high
`define DG_PIN_IDLE    3'b100
// timing counts
`define DG_CNT_SAT     6'h3f
`endif

// ==== pkg/spi_datagram_pkg.sv ====
/*
 * types shared by the serial datagram port.
 * assumes spi_datagram_map.svh is on the include path.
 */
package spi_datagram_pkg;
  typedef logic [6:0]  reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [7:0]  status_byte_t;
  typedef enum logic [1:0] {
    link_idle,
    link_shift,
    link_done
  } link_state_t;
endpackage : spi_datagram_pkg

// ==== rtl/pin_sync.sv ====
/*
 * two-flop synchroniser for the link pins.
 * assumes pins are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module pin_sync (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clk_en,
  input  wire logic pin_in,
  input  wire logic reset_level,
  output logic      pin_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (clk_en) begin
      meta_d = pin_in;
      sync_d = meta_q;
    end
  end

  // reset_level is tied to a constant by the parent
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_q <= reset_level;
      sync_q <= reset_level;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pin_out = sync_q;
endmodule : pin_sync

// ==== rtl/spi_slave_datagram_port.sv ====
/*
 * serial datagram slave: 40-bit frames, status byte first, pipelined read back.
 * assumes the register file sits outside and answers rd_data in the cycle
 * cmd_valid pulses; link pins are asynchronous and sampled on sys_clk.
 */
`timescale 1ns/1ps
`include "spi_datagram_map.svh"

// How it works
// (RULE_01) frame starts only after select falls; bits before it are ignored.
// (RULE_02) sample input on clock rise, change output after clock fall.
// (RULE_03) most significant bit goes first in both directions.
// (RULE_04) master gives at least 40 clocks per complete frame.
// (RULE_05) first eight bits out are the status byte every frame.
// (RULE_06) fewer than 40 clocks: frame dropped, no read, no write.
// (RULE_07) eight-clock frame just returns the status byte, nothing else.
// (RULE_08) extra bits beyond 40 come out delayed by 40 clocks.
// (RULE_09) master holds select low for the whole frame.
// (RULE_10) select rising latches shift register as command and executes it.
// (RULE_11) longer frames use only the last 40 bits as command.
// (RULE_12) port runs on system clock; link clock at most a quarter.
// (RULE_13) bit 39 is write flag, next seven bits the address.
// (RULE_14) every datagram carries 32 data bits.
// (RULE_15) read returns register content captured at request in next frame.
// (RULE_16) write returns copy of written data in next frame.
// (RULE_17) invalid frame leaves pending return data untouched.
module spi_slave_datagram_port
  import spi_datagram_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      clk_en,
  input  wire logic                      spi_select_n,
  input  wire logic                      spi_serial_clock,
  input  wire logic                      spi_serial_in,
  output logic                           spi_serial_out,
  input  wire spi_datagram_pkg::status_byte_t link_status_byte,
  output logic                           cmd_valid,
  output logic                           cmd_write,
  output spi_datagram_pkg::reg_addr_t    cmd_addr,
  output spi_datagram_pkg::reg_data_t    cmd_data,
  input  wire spi_datagram_pkg::reg_data_t rd_data
);
  // sampled pins: select, link clock, data in
  localparam logic [2:0] pin_idle = `DG_PIN_IDLE;

  logic       [2:0] pin_raw;
  wire  logic [2:0] pin_s;
  logic             sel_n_s;
  logic             sck_s;
  logic             sdi_s;

  assign pin_raw = {spi_select_n, spi_serial_clock, spi_serial_in};

  // every pin comes from the host's clock, so it passes two flops before use
  for (genvar g = 0; g < 3; g++) begin : g_pin
    pin_sync u_sync (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .clk_en      (clk_en),
      .pin_in      (pin_raw[g]),
      .reset_level (pin_idle[g]),
      .pin_out     (pin_s[g])
    );
  end

  assign sel_n_s = pin_s[2];
  assign sck_s   = pin_s[1];
  assign sdi_s   = pin_s[0];

  link_state_t           state_q;
  link_state_t           state_d;
  logic                  sel_prev_q;
  logic                  sel_prev_d;
  logic                  sck_prev_q;
  logic                  sck_prev_d;
  logic [`DG_BITS-1:0]   rx_q;
  logic [`DG_BITS-1:0]   rx_d;
  logic [`DG_BITS-1:0]   tx_q;
  logic [`DG_BITS-1:0]   tx_d;
  logic [5:0]            cnt_q;
  logic [5:0]            cnt_d;
  reg_data_t             ret_q;
  reg_data_t             ret_d;
  logic                  sdo_q;
  logic                  sdo_d;
  logic                  cv_q;
  logic                  cv_d;
  logic                  cw_q;
  logic                  cw_d;
  reg_addr_t             ca_q;
  reg_addr_t             ca_d;
  reg_data_t             cd_q;
  reg_data_t             cd_d;
  logic                  rd_pend_q;
  logic                  rd_pend_d;

  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  logic sel_rise;

  assign sck_rise = sck_s && !sck_prev_q;     // RULE_12
  assign sck_fall = !sck_s && sck_prev_q;     // RULE_12
  assign sel_fall = !sel_n_s && sel_prev_q;
  assign sel_rise = sel_n_s && !sel_prev_q;

  logic frame_open;
  logic bit_in;
  logic bit_out;
  logic frame_end;
  logic frame_ok;

  assign frame_open = (state_q == link_idle) && sel_fall;
  assign bit_in     = (state_q == link_shift) && !sel_rise && sck_rise;
  assign bit_out    = (state_q == link_shift) && !sel_rise && sck_fall;
  assign frame_end  = (state_q == link_done);
  // a frame is a command only with 40 or more link clocks
  assign frame_ok   = frame_end && (cnt_q >= 6'(`DG_BITS));

  // edge history of the synchronised pins
  always_comb begin
    sel_prev_d = sel_prev_q;
    sck_prev_d = sck_prev_q;
    if (clk_en) begin
      sel_prev_d = sel_n_s;
      sck_prev_d = sck_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sel_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_prev_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  // frame sequencer
  always_comb begin
    state_d = state_q;
    if (clk_en) begin
      case (state_q)
        link_idle: begin
          if (sel_fall) begin                            // RULE_01
            state_d = link_shift;
          end
        end
        link_shift: begin
          if (sel_rise) begin                            // RULE_09
            state_d = link_done;
          end
        end
        link_done: begin
          state_d = link_idle;
        end
        default: begin
          state_d = link_idle;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= link_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // rising link edges in this frame, saturating so long daisy chains cannot wrap
  always_comb begin
    cnt_d = cnt_q;
    if (clk_en) begin
      if (frame_open) begin
        cnt_d = 6'h00;
      end else if (bit_in && (cnt_q != `DG_CNT_SAT)) begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // receive shift: the newest 40 bits are the command
  always_comb begin
    rx_d = rx_q;
    if (clk_en && bit_in) begin
      rx_d = {rx_q[`DG_BITS-2:0], sdi_s};              // RULE_02 RULE_03 RULE_11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  // transmit shift: status byte and return word, then the input 40 clocks late
  always_comb begin
    tx_d = tx_q;
    if (clk_en) begin
      if (frame_open) begin
        tx_d = {link_status_byte, ret_q};              // RULE_05 RULE_14
      end else if (bit_in) begin
        // refill with the bit just taken so it reaches the top 39 clocks later
        tx_d = {tx_q[`DG_BITS-2:0], sdi_s};            // RULE_08
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // serial output: status msb at frame open, next bit after each link fall
  always_comb begin
    sdo_d = sdo_q;
    if (clk_en) begin
      if (frame_open) begin
        sdo_d = link_status_byte[`DG_STATUS_BITS-1];   // RULE_03
      end else if (bit_out) begin
        sdo_d = tx_q[`DG_BITS-1];                      // RULE_02
      end else if (frame_end) begin
        sdo_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  // command outputs: one pulse per valid frame, fields held until the next
  always_comb begin
    cv_d      = 1'b0;
    cw_d      = cw_q;
    ca_d      = ca_q;
    cd_d      = cd_q;
    rd_pend_d = 1'b0;
    if (!clk_en) begin
      cv_d      = cv_q;
      rd_pend_d = rd_pend_q;
    end else if (frame_ok) begin                       // RULE_06 RULE_07
      cv_d      = 1'b1;                                // RULE_10
      cw_d      = rx_q[`DG_WRITE_BIT];                 // RULE_13
      ca_d      = rx_q[`DG_ADDR_HI:`DG_ADDR_LO];       // RULE_13
      cd_d      = rx_q[`DG_DATA_HI:0];                 // RULE_14
      rd_pend_d = !rx_q[`DG_WRITE_BIT];                // RULE_15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cv_q      <= 1'b0;
      cw_q      <= 1'b0;
      ca_q      <= '0;
      cd_q      <= '0;
      rd_pend_q <= 1'b0;
    end else begin
      cv_q      <= cv_d;
      cw_q      <= cw_d;
      ca_q      <= ca_d;
      cd_q      <= cd_d;
      rd_pend_q <= rd_pend_d;
    end
  end

  // return word for the next frame; a dropped frame leaves it as it is
  always_comb begin
    ret_d = ret_q;
    if (clk_en) begin
      if (rd_pend_q) begin
        // the register file answers while the command pulse stands
        ret_d = rd_data;                               // RULE_15
      end else if (frame_ok && rx_q[`DG_WRITE_BIT]) begin
        ret_d = rx_q[`DG_DATA_HI:0];                   // RULE_16 RULE_17
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ret_q <= `DG_RET_RESET;
    end else begin
      ret_q <= ret_d;
    end
  end

  assign spi_serial_out = sdo_q;
  assign cmd_valid      = cv_q;
  assign cmd_write      = cw_q;
  assign cmd_addr       = ca_q;
  assign cmd_data       = cd_q;
endmodule : spi_slave_datagram_port

// ==== tb/spi_master_model.sv ====
/* master model of the datagram link: frames of n clocks, msb first.
   assumes sys_clk is the bench clock; half period of the link in sys_clk cycles. */
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic sys_clk,
  output logic      spi_select_n,
  output logic      spi_serial_clock,
  output logic      spi_serial_in,
  input  wire logic spi_serial_out
);
  logic [79:0] rx = '0;
  int          half = 4;
  initial begin
    spi_select_n     = 1'b1;
    spi_serial_clock = 1'b0;
    spi_serial_in    = 1'b0;
  end
  task automatic xfer(input int n, input logic [79:0] tx);
    spi_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_serial_in <= tx[i];
      repeat (half) @(posedge sys_clk);
      spi_serial_clock <= 1'b1;
      rx <= {rx[78:0], spi_serial_out};
      repeat (half) @(posedge sys_clk);
      spi_serial_clock <= 1'b0;
    end
    repeat (half) @(posedge sys_clk);
    spi_select_n  <= 1'b1;
    // released line flips so a stale bit is never read as data
    spi_serial_in <= ~spi_serial_in;
    repeat (12) @(posedge sys_clk);
  endtask : xfer
endmodule : spi_master_model

// ==== tb/spi_slave_datagram_port_checker.sv ====
/* timing checks on the datagram port pins and command outputs.
   assumes link_status_byte is steady while a frame runs. */
`timescale 1ns/1ps
module spi_slave_datagram_port_checker
  import spi_datagram_pkg::*;
(
  input wire logic                          sys_clk,
  input wire logic                          rst_b,
  input wire logic                          clk_en,
  input wire logic                          spi_select_n,
  input wire logic                          spi_serial_clock,
  input wire logic                          spi_serial_in,
  input wire logic                          spi_serial_out,
  input wire spi_datagram_pkg::status_byte_t link_status_byte,
  input wire logic                          cmd_valid,
  input wire logic                          cmd_write,
  input wire spi_datagram_pkg::reg_addr_t    cmd_addr,
  input wire spi_datagram_pkg::reg_data_t    cmd_data,
  input wire spi_datagram_pkg::reg_data_t    rd_data
);
  logic [5:0] rises_q;
  logic       sck_q;
  logic       sel_q;
  // rising link edges seen in the current frame, held until the next opens
  always_ff @(posedge sys_clk) begin
    sck_q <= spi_serial_clock;
    sel_q <= spi_select_n;
    if (!rst_b || (!spi_select_n && sel_q)) rises_q <= '0;
    else if (!spi_select_n && spi_serial_clock && !sck_q && rises_q != 6'h3f)
      rises_q <= rises_q + 6'h01;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  pulse_once_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("cmd_valid too long");
  full_frame_a: assert property (cmd_valid |-> rises_q >= 6'd40)
    else $error("command from short frame");
  sel_high_a: assert property (cmd_valid |-> spi_select_n && $past(spi_select_n, 3))
    else $error("command before select rose");
  fields_hold_a: assert property ($changed({cmd_write, cmd_addr, cmd_data}) |-> cmd_valid)
    else $error("command fields moved");
  exec_rise_a: assert property ($rose(spi_select_n) && clk_en && rises_q >= 6'd40 |-> ##[3:6] cmd_valid)
    else $error("no command after frame");
  status_msb_a: assert property ($fell(spi_select_n) && clk_en |-> ##[3:5] spi_serial_out == link_status_byte[7])
    else $error("first bit not status msb");
  idle_low_a: assert property (spi_select_n [*6] |-> !spi_serial_out)
    else $error("output active while idle");
  out_on_fall_a: assert property ($changed(spi_serial_out) && !spi_select_n && !$past(spi_select_n, 6) |-> !$past(spi_serial_clock, 2))
    else $error("output moved off falling edge");
endmodule : spi_slave_datagram_port_checker
bind spi_slave_datagram_port spi_slave_datagram_port_checker u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .spi_select_n(spi_select_n),
  .spi_serial_clock(spi_serial_clock), .spi_serial_in(spi_serial_in),
  .spi_serial_out(spi_serial_out), .link_status_byte(link_status_byte),
  .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
  .cmd_data(cmd_data), .rd_data(rd_data));

// ==== tb/spi_slave_datagram_port_tb_top.sv ====
/* self-checking bench for the datagram port, driven by the master model.
   assumes the package, header and checker are compiled first. */
`timescale 1ns/1ps
module spi_slave_datagram_port_tb_top;
  import spi_datagram_pkg::*;
  logic         sys_clk, rst_b, clk_en, sel_n, sck, sdi, sdo, cmd_valid, cmd_write;
  status_byte_t stat;
  reg_addr_t    cmd_addr;
  reg_data_t    cmd_data, rd_data;
  logic [39:0]  last_cmd = '0;
  int           n_fail = 0, compares = 0;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  spi_master_model u_mst (.sys_clk(sys_clk), .spi_select_n(sel_n), .spi_serial_clock(sck),
    .spi_serial_in(sdi), .spi_serial_out(sdo));
  spi_slave_datagram_port u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .spi_select_n(sel_n), .spi_serial_clock(sck), .spi_serial_in(sdi), .spi_serial_out(sdo),
    .link_status_byte(stat), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rd_data(rd_data));
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1) last_cmd <= {cmd_write, cmd_addr, cmd_data};
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic t_write_read();
    stat <= 8'ha5;
    u_mst.xfer(40, 80'h95deadbeef);
    chk(u_mst.rx[39:0], 40'ha500000000);
    chk(last_cmd, 40'h95deadbeef);
    stat    <= 8'h3c;
    rd_data <= 32'hcafe0021;
    u_mst.xfer(40, 80'h2100000000);
    chk(u_mst.rx[39:0], 40'h3cdeadbeef);
    $display("t_write_read done");
  endtask : t_write_read
  task automatic t_short();
    rd_data <= 32'h0bad0bad;
    u_mst.xfer(8, 80'hff);
    chk({32'h0, u_mst.rx[7:0]}, 40'h3c);
    u_mst.xfer(20, 80'hfffff);
    chk(last_cmd, 40'h2100000000);
    u_mst.xfer(40, 80'h8200abcdef);
    chk(u_mst.rx[39:0], 40'h3ccafe0021);
    $display("t_short done");
  endtask : t_short
  task automatic t_long();
    u_mst.xfer(48, 80'h96a200123456);
    chk(u_mst.rx[47:8], 40'h3c00abcdef);
    chk({32'h0, u_mst.rx[7:0]}, 40'h96);
    chk(last_cmd, 40'ha200123456);
    $display("t_long done");
  endtask : t_long
  task automatic t_freeze();
    // a frame run while the enable is low must leave no trace
    clk_en <= 1'b0;
    u_mst.xfer(40, 80'h95ffffffff);
    clk_en <= 1'b1;
    chk(last_cmd, 40'ha200123456);
    u_mst.xfer(40, 80'h2100000000);
    chk(u_mst.rx[39:0], 40'h3c00123456);
    $display("t_freeze done");
  endtask : t_freeze
  initial begin
    rst_b   = 1'b0;
    clk_en  = 1'b1;
    stat    = 8'h00;
    rd_data = 32'h00000000;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_write_read();
    t_short();
    t_long();
    t_freeze();
    test_done();
  end
  initial begin
    #500us;
    n_fail++;
    test_done();
  end
endmodule : spi_slave_datagram_port_tb_top
